// *** verilog/i2c_slave_consts.vh ***
/*
 * Constants for the two-wire bus slave: register byte offsets, control and
 * status field positions, reset values and bus response codes.
 * Assumes it is included by bare name from the slave's design file.
 */
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------------
`define OFS_RECEIVE_BUFFER 8'h00
`define OFS_TRANSMIT_HOLDING 8'h04
`define OFS_BAUD_RELOAD 8'h08
`define OFS_CONTROL_WORD 8'h0c
`define OFS_STATUS_WORD 8'h10
`define OFS_OWN_ADDRESS 8'h14

// ----------------------------------------------------------------------
// control_word fields
// ----------------------------------------------------------------------
`define CTL_MODULE_ENABLE 15
`define CTL_CLOCK_RELEASE 12
`define CTL_LONG_ADDRESS 10
`define CTL_STRETCH_ENABLE 6

// ----------------------------------------------------------------------
// status_word fields; bits below STS_RO_WIDTH are read-only
// ----------------------------------------------------------------------
`define STS_RO_WIDTH 6
`define STS_TX_FULL 0
`define STS_RX_FULL 1
`define STS_READ_DIR 2
`define STS_DATA_PHASE 3
`define STS_STOP_SEEN 4
`define STS_FULL_MATCH 5
`define STS_OVERFLOW 6

// ----------------------------------------------------------------------
// reset values, address prefix, bus responses
// ----------------------------------------------------------------------
`define CONTROL_RESET 16'h1000
`define STATUS_HI_RESET 10'h000
`define BAUD_RESET 9'h000
`define OWN_ADDRESS_RESET 10'h000
`define TEN_BIT_PREFIX 5'h1e
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verilog/i2c_slave.v ***
/*
 * Two-wire bus slave with 7-bit and 10-bit addressing, a double-buffered
 * receiver, a single transmit holding register and an AXI4-Lite register
 * port. Assumes an external master drives SCL, open-drain pins with an
 * external pull-up, and SCL slow enough to be sampled by the 100 MHz clock.
 */
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_consts.vh"

// Operation
// - status low six bits read-only, upper bits writable; control writable, but clock release only clears under stretch enable
// - completed byte moves from shifter to receive buffer with an event
// - transmit path has one holding register, no second stage
// - after repeated start in 10-bit mode a read after full match compares only the high part
// - own address register is 10 bits and holds the whole address
// - long address select clear: compare only seven low address bits
// - 7-bit space: general call, reserved, ordinary, 10-bit prefix 11110xx
// - when enabled, idle until start, then shift 8 bits and compare
// - 7-bit mode: address bits 6..0 against shifter 7..1, bit 0 direction
// - every incoming bit is sampled on the rising SCL edge
// - address match: acknowledge, event on ninth falling edge, buffer untouched
// - read direction: acknowledge, hold SCL until data loaded and released
// - transmit data changes on falling SCL edges, or at a stretched load while SCL is held low
// - transmit event on every ninth falling edge, acknowledged or not
// - write direction: store byte only if buffer empty and no overflow
// - buffer still full: no acknowledge, buffer kept, event still pulsed
// - overflow set with buffer empty: not-acknowledge until software clears it
// - 10-bit high byte 11110 plus address 9..8, write: event, clear match
// - second byte against address 7..0: event and set full match
// - after full match, repeated start with read begins slave transmit
// - transmit stretches after ninth clock when holding register empty, unless the master did not acknowledge
module i2c_slave (
	input wire clock,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sclIn,
	output reg sclOut,
	output reg sclOeN,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOeN,
	output reg slaveEvent
);

	// ------------------------------------------------------------------
	// protocol states
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ADDR_LOW = 3'h2;
	localparam [2:0] ST_RECEIVE = 3'h3;
	localparam [2:0] ST_TRANSMIT = 3'h4;
	localparam [2:0] ST_WAIT = 3'h5;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	reg sclSync1_reg, sclSync2_reg, sclPrev_reg;
	reg sdaSync1_reg, sdaSync2_reg, sdaPrev_reg;
	reg [2:0] state_reg;
	reg [3:0] bitCount_reg;
	reg [7:0] receiveShifter_reg;
	reg [7:0] receiveBuffer_reg;
	reg [7:0] transmitHolding_reg;
	reg [8:0] baudReload_reg;
	reg [15:0] controlWord_reg;
	reg [15:6] statusHigh_reg;
	reg [9:0] ownSlaveAddress_reg;
	reg transmitFull_reg, receiveFull_reg, readDir_reg, dataPhase_reg;
	reg stopSeen_reg, tenBitFullMatch_reg, needLoad_reg, sdaLow_reg, masterAck_reg;
	reg releaseHold_reg;
	reg awHave_reg, wHave_reg;
	reg [7:0] awAddr_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	wire sclRise, sclFall, startCond, stopCond;
	wire moduleEnable, longAddress, stretchEnable, clockRelease;
	wire match7, matchHigh, matchLow, addrAck;
	wire [15:0] wMask;
	wire [15:0] statusWord;
	reg [31:0] readMux;
	reg readHit;

	// ------------------------------------------------------------------
	// pin synchronisers and edge detection
	// ------------------------------------------------------------------
	// two flops before any logic reads the pins; edges come from the second
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sclSync1_reg <= 1'b1;
			sclSync2_reg <= 1'b1;
			sclPrev_reg <= 1'b1;
			sdaSync1_reg <= 1'b1;
			sdaSync2_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclSync1_reg <= sclIn;
			sclSync2_reg <= sclSync1_reg;
			sclPrev_reg <= sclSync2_reg;
			sdaSync1_reg <= sdaIn;
			sdaSync2_reg <= sdaSync1_reg;
			sdaPrev_reg <= sdaSync2_reg;
		end
	end

	assign sclRise = sclSync2_reg & ~sclPrev_reg;
	assign sclFall = ~sclSync2_reg & sclPrev_reg;
	// start and stop are SDA edges while SCL stays high
	assign startCond = sclSync2_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync2_reg;
	assign stopCond = sclSync2_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync2_reg;

	// ------------------------------------------------------------------
	// control fields and address comparators
	// ------------------------------------------------------------------
	assign moduleEnable = controlWord_reg[`CTL_MODULE_ENABLE];
	assign longAddress = controlWord_reg[`CTL_LONG_ADDRESS];
	assign stretchEnable = controlWord_reg[`CTL_STRETCH_ENABLE];
	assign clockRelease = controlWord_reg[`CTL_CLOCK_RELEASE];
	assign match7 = ~longAddress & (receiveShifter_reg[7:1] == ownSlaveAddress_reg[6:0]);
	assign matchHigh = longAddress & (receiveShifter_reg[7:3] == `TEN_BIT_PREFIX) &
		(receiveShifter_reg[2:1] == ownSlaveAddress_reg[9:8]);
	assign matchLow = receiveShifter_reg == ownSlaveAddress_reg[7:0];
	// read after full match needs only the high part
	assign addrAck = match7 | (matchHigh & (~receiveShifter_reg[0] | tenBitFullMatch_reg));

	// byte lanes for the 16-bit registers; upper lanes hold nothing
	assign wMask = {{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
	assign statusWord = {statusHigh_reg, tenBitFullMatch_reg, stopSeen_reg, dataPhase_reg,
		readDir_reg, receiveFull_reg, transmitFull_reg};

	// ------------------------------------------------------------------
	// read data multiplexer
	// ------------------------------------------------------------------
	// narrower registers sit in the low bits, the rest reads zero
	always @* begin
		readMux = 32'h0000_0000;
		readHit = 1'b1;
		case (s_axi_araddr)
			`OFS_RECEIVE_BUFFER: readMux[7:0] = receiveBuffer_reg;
			`OFS_TRANSMIT_HOLDING: readMux[7:0] = transmitHolding_reg;
			`OFS_BAUD_RELOAD: readMux[8:0] = baudReload_reg;
			`OFS_CONTROL_WORD: readMux[15:0] = controlWord_reg;
			`OFS_STATUS_WORD: readMux[15:0] = statusWord;
			`OFS_OWN_ADDRESS: readMux[9:0] = ownSlaveAddress_reg;
			default: readHit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// bus slave and protocol engine
	// ------------------------------------------------------------------
	// one process: the protocol part comes last so a hardware set wins
	// over a software clear landing in the same cycle
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
			awHave_reg <= 1'b0;
			wHave_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			state_reg <= ST_IDLE;
			bitCount_reg <= 4'h0;
			receiveShifter_reg <= 8'h00;
			receiveBuffer_reg <= 8'h00;
			transmitHolding_reg <= 8'h00;
			baudReload_reg <= `BAUD_RESET;
			controlWord_reg <= `CONTROL_RESET;
			statusHigh_reg <= `STATUS_HI_RESET;
			ownSlaveAddress_reg <= `OWN_ADDRESS_RESET;
			transmitFull_reg <= 1'b0;
			receiveFull_reg <= 1'b0;
			readDir_reg <= 1'b0;
			dataPhase_reg <= 1'b0;
			stopSeen_reg <= 1'b0;
			tenBitFullMatch_reg <= 1'b0;
			needLoad_reg <= 1'b0;
			sdaLow_reg <= 1'b0;
			masterAck_reg <= 1'b0;
			slaveEvent <= 1'b0;
		end else begin
			slaveEvent <= 1'b0;
			// write address and data are taken in either order
			if (s_axi_awready && s_axi_awvalid) begin
				awAddr_reg <= s_axi_awaddr;
				awHave_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
				wHave_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// both halves present: commit the write and answer
			if (awHave_reg && wHave_reg) begin
				awHave_reg <= 1'b0;
				wHave_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (awAddr_reg)
					`OFS_TRANSMIT_HOLDING: begin
						if (!transmitFull_reg && wStrb_reg[0]) begin
							transmitHolding_reg <= wData_reg[7:0];
							transmitFull_reg <= 1'b1;
						end
					end
					`OFS_BAUD_RELOAD: begin
						baudReload_reg <= (baudReload_reg & wMask[8:0]) ^ baudReload_reg |
							(wData_reg[8:0] & wMask[8:0]);
					end
					`OFS_CONTROL_WORD: begin
						controlWord_reg <= (controlWord_reg & ~wMask) | (wData_reg[15:0] & wMask);
						// releasing always works, holding only under stretch enable
						if (wStrb_reg[1] && !wData_reg[`CTL_CLOCK_RELEASE] && !stretchEnable)
							controlWord_reg[`CTL_CLOCK_RELEASE] <= clockRelease;
					end
					`OFS_STATUS_WORD: begin
						statusHigh_reg <= (statusHigh_reg & ~wMask[15:6]) |
							(wData_reg[15:6] & wMask[15:6]);
					end
					`OFS_OWN_ADDRESS: begin
						ownSlaveAddress_reg <= (ownSlaveAddress_reg & ~wMask[9:0]) |
							(wData_reg[9:0] & wMask[9:0]);
					end
					`OFS_RECEIVE_BUFFER: s_axi_bresp <= `RESP_OKAY;
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			// reads answer one cycle after the address is taken
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readMux;
				s_axi_rresp <= readHit ? `RESP_OKAY : `RESP_SLVERR;
				// reading the buffer empties it
				if (s_axi_araddr == `OFS_RECEIVE_BUFFER)
					receiveFull_reg <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end

			// protocol engine
			if (!moduleEnable) begin
				state_reg <= ST_IDLE;
				sdaLow_reg <= 1'b0;
				needLoad_reg <= 1'b0;
			end else if (startCond) begin
				state_reg <= ST_ADDR;
				bitCount_reg <= 4'h0;
				sdaLow_reg <= 1'b0;
				needLoad_reg <= 1'b0;
				stopSeen_reg <= 1'b0;
				dataPhase_reg <= 1'b0;
			end else if (stopCond) begin
				state_reg <= ST_IDLE;
				sdaLow_reg <= 1'b0;
				needLoad_reg <= 1'b0;
				tenBitFullMatch_reg <= 1'b0;
				stopSeen_reg <= 1'b1;
			end else begin
				// stretched transmit resumes once data and release are both there
				if (needLoad_reg && transmitFull_reg && clockRelease) begin
					receiveShifter_reg <= transmitHolding_reg;
					transmitFull_reg <= 1'b0;
					sdaLow_reg <= ~transmitHolding_reg[7];
					needLoad_reg <= 1'b0;
				end
				if (sclRise) begin
					// data and address taken on rising edge
					if (state_reg == ST_TRANSMIT) begin
						if (bitCount_reg == 4'h8)
							masterAck_reg <= ~sdaSync2_reg;
						bitCount_reg <= bitCount_reg + 4'h1;
					end else if (state_reg == ST_ADDR || state_reg == ST_ADDR_LOW ||
						state_reg == ST_RECEIVE) begin
						if (bitCount_reg < 4'h8)
							receiveShifter_reg <= {receiveShifter_reg[6:0], sdaSync2_reg};
						bitCount_reg <= bitCount_reg + 4'h1;
					end
				end
				if (sclFall) begin
					case (state_reg)
						ST_ADDR: begin
							if (bitCount_reg == 4'h8) begin
								sdaLow_reg <= addrAck;
								readDir_reg <= receiveShifter_reg[0];
								if (!addrAck) begin
									state_reg <= ST_WAIT;
									if (longAddress)
										tenBitFullMatch_reg <= 1'b0;
								end
							end else if (bitCount_reg == 4'h9) begin
								// event on ninth falling edge, buffer untouched
								sdaLow_reg <= 1'b0;
								slaveEvent <= 1'b1;
								bitCount_reg <= 4'h0;
								if (longAddress && !readDir_reg) begin
									tenBitFullMatch_reg <= 1'b0;
									state_reg <= ST_ADDR_LOW;
								end else if (readDir_reg) begin
									state_reg <= ST_TRANSMIT;
									dataPhase_reg <= 1'b1;
									if (transmitFull_reg && clockRelease) begin
										receiveShifter_reg <= transmitHolding_reg;
										transmitFull_reg <= 1'b0;
										sdaLow_reg <= ~transmitHolding_reg[7];
									end else begin
										needLoad_reg <= 1'b1;
										controlWord_reg[`CTL_CLOCK_RELEASE] <= 1'b0;
									end
								end else begin
									state_reg <= ST_RECEIVE;
									dataPhase_reg <= 1'b1;
								end
							end
						end
						ST_ADDR_LOW: begin
							if (bitCount_reg == 4'h8) begin
								sdaLow_reg <= matchLow;
								if (!matchLow) begin
									tenBitFullMatch_reg <= 1'b0;
									state_reg <= ST_WAIT;
								end
							end else if (bitCount_reg == 4'h9) begin
								sdaLow_reg <= 1'b0;
								slaveEvent <= 1'b1;
								tenBitFullMatch_reg <= 1'b1;
								bitCount_reg <= 4'h0;
								state_reg <= ST_RECEIVE;
								dataPhase_reg <= 1'b1;
							end
						end
						ST_RECEIVE: begin
							if (bitCount_reg == 4'h8) begin
								if (!receiveFull_reg && !statusHigh_reg[`STS_OVERFLOW]) begin
									receiveBuffer_reg <= receiveShifter_reg;
									receiveFull_reg <= 1'b1;
									sdaLow_reg <= 1'b1;
								end else begin
									sdaLow_reg <= 1'b0;
									if (receiveFull_reg)
										statusHigh_reg[`STS_OVERFLOW] <= 1'b1;
								end
							end else if (bitCount_reg == 4'h9) begin
								sdaLow_reg <= 1'b0;
								slaveEvent <= 1'b1;
								bitCount_reg <= 4'h0;
								if (stretchEnable && receiveFull_reg)
									controlWord_reg[`CTL_CLOCK_RELEASE] <= 1'b0;
							end
						end
						ST_TRANSMIT: begin
							if (bitCount_reg >= 4'h1 && bitCount_reg <= 4'h7) begin
								receiveShifter_reg <= {receiveShifter_reg[6:0], 1'b0};
								sdaLow_reg <= ~receiveShifter_reg[6];
							end else if (bitCount_reg == 4'h8) begin
								sdaLow_reg <= 1'b0;
							end else if (bitCount_reg == 4'h9) begin
								slaveEvent <= 1'b1;
								bitCount_reg <= 4'h0;
								if (!masterAck_reg) begin
									state_reg <= ST_WAIT;
								end else if (transmitFull_reg && clockRelease) begin
									receiveShifter_reg <= transmitHolding_reg;
									transmitFull_reg <= 1'b0;
									sdaLow_reg <= ~transmitHolding_reg[7];
								end else begin
									needLoad_reg <= 1'b1;
									controlWord_reg[`CTL_CLOCK_RELEASE] <= 1'b0;
								end
							end
						end
						default: sdaLow_reg <= 1'b0;
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// open-drain pin drivers
	// ------------------------------------------------------------------
	// pull low only, release otherwise; SCL is only grabbed
	// while already low so the master's high time is never cut short
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			sclOeN <= 1'b1;
			sdaOeN <= 1'b1;
			releaseHold_reg <= 1'b0;
		end else begin
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
			// hold outlives the load by one cycle so the first data bit
			// is settled on SDA before SCL is let go
			releaseHold_reg <= needLoad_reg;
			sclOeN <= ~(moduleEnable & ~sclSync2_reg &
				(~clockRelease | needLoad_reg | releaseHold_reg));
			sdaOeN <= ~(moduleEnable & sdaLow_reg);
		end
	end

endmodule // i2c_slave

`default_nettype wire

// *** verif/i2c_slave_properties.sv ***
/* checker on the two-wire slave ports.
   assumes the i2c_slave top; bound at the foot. */
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic sclIn,
	input wire logic sclOut,
	input wire logic sclOeN,
	input wire logic sdaOut,
	input wire logic sdaOeN,
	input wire logic slaveEvent
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ------
	// link and bus relations
	// ------
	AST_PINS_LOW: assert property (!sclOut && !sdaOut)
		else $error("pin driven high");
	AST_EVENT_PULSE: assert property (slaveEvent |=> !slaveEvent)
		else $error("event longer than one cycle");
	AST_EVENT_SCL_LOW: assert property (slaveEvent |-> !sclIn)
		else $error("event while clock high");
	AST_SDA_CHANGE_LOW: assert property ($changed(sdaOeN) |-> !sclIn)
		else $error("data moved while clock high");
	AST_SCL_GRAB_LOW: assert property ($fell(sclOeN) |-> !sclIn)
		else $error("clock grabbed while high");
	AST_WRITE_RESP: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_READ_RESP: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read response late");
	AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
endmodule // i2c_slave_properties
bind i2c_slave i2c_slave_properties u_props (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.sclIn, .sclOut, .sclOeN, .sdaOut, .sdaOeN, .slaveEvent);
`default_nettype wire

// *** verif/i2c_master_model.sv ***
/* behavioural bus master driving the clock line, 80 ns bit period.
   assumes the slave's active-low pin enables; lines pulled up. */
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
	input wire logic sclOeN,
	input wire logic sdaOeN,
	output wire logic sclPin,
	output wire logic sdaPin
);
	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;
	assign sclPin = sclDrv & sclOeN;
	assign sdaPin = sdaDrv & sdaOeN;
	// start or repeated start; waits out a stretched clock
	task automatic start();
		sdaDrv = 1'b1;
		#50 sclDrv = 1'b1;
		wait (sclPin);
		#40 sdaDrv = 1'b0;
		#40 sclDrv = 1'b0;
	endtask
	task automatic stop();
		sdaDrv = 1'b0;
		#50 sclDrv = 1'b1;
		wait (sclPin);
		#40 sdaDrv = 1'b1;
		#40;
	endtask
	// low 50 ns, high 30 ns; sampled mid high so late slave edges still read
	task automatic bitX(input logic b, output logic s);
		sdaDrv = b;
		#50 sclDrv = 1'b1;
		wait (sclPin);
		#15 s = sdaPin;
		#15 sclDrv = 1'b0;
	endtask
	// msb first, then the acknowledge slot
	task automatic byteX(input logic [7:0] v, input logic ackBit, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			bitX(v[i], q[i]);
		bitX(ackBit, ack);
	endtask
endmodule // i2c_master_model
`default_nettype wire

// *** verif/tb_i2c_slave.sv ***
/* self-checking bench: register bus tasks, link traffic, queued reads.
   assumes the consts header on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_consts.vh"
module tb_i2c_slave;
	localparam logic [1:0] OK = `RESP_OKAY;
	localparam logic [1:0] ER = `RESP_SLVERR;
	logic clock = 0;
	logic rst = 1;
	logic [7:0] awaddr = 0, araddr = 0, q, d;
	logic [31:0] wdata = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ack;
	wire awready, wready, bvalid, arready, rvalid, sclOut, sclOeN, sdaOut, sdaOeN, slaveEvent;
	wire sclPin, sdaPin;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [33:0] expQ[$];
	logic [9:0] adr;
	int num_errors = 0, checked = 0, evCnt = 0, seed = 46;
	i2c_slave u_i2c_slave (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclIn(sclPin),
		.sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.slaveEvent(slaveEvent));
	i2c_master_model u_master (.sclOeN(sclOeN), .sdaOeN(sdaOeN), .sclPin(sclPin), .sdaPin(sdaPin));
	// ------
	// clock, event counter, read monitor
	// ------
	initial forever #5 clock = ~clock;
	always @(posedge clock) if (slaveEvent === 1'b1) evCnt++;
	always @(posedge clock) if (rvalid === 1'b1 && rready) cmpReg("rdata", expQ.pop_front(), {rresp, rdata});
	task automatic cmpReg(input string n, input logic [33:0] e, input logic [33:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmpLink(input string n, input logic [7:0] e, input logic [7:0] g);
		cmpReg(n, {26'h0, e}, {26'h0, g});
	endtask
	// address and data offered together, each dropped when taken
	task automatic axiWr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			aw |= awready;
			w |= wready;
		end while (!(aw && w));
		while (bvalid !== 1'b1) @(posedge clock);
		bready <= 0;
		cmpReg("bresp", {32'h0, r}, {32'h0, bresp});
	endtask
	task automatic axiRd(input logic [7:0] a, input logic [33:0] e);
		expQ.push_back(e);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge clock); while (rvalid !== 1'b1);
		rready <= 0;
	endtask
	task automatic linkByte(input logic [7:0] v, input logic e);
		u_master.byteX(v, 1'b1, q, ack);
		cmpLink("ack", {7'h0, e}, {7'h0, ack});
	endtask
	// slave answers a read; software loads and releases while the clock is held
	task automatic rdPhase(input logic [7:0] h, input logic [7:0] v, input logic [31:0] ctl);
		logic a1, a2;
		logic [7:0] got;
		evCnt = 0;
		fork
			begin
				u_master.byteX(h, 1'b1, q, a1);
				u_master.byteX(8'hff, 1'b1, got, a2);
			end
			begin
				repeat (120) @(posedge clock);
				cmpLink("sclOeN", 8'h00, {7'h0, sclOeN});
				axiWr(`OFS_TRANSMIT_HOLDING, {24'h0, v}, OK);
				axiWr(`OFS_TRANSMIT_HOLDING, {24'h0, ~v}, OK);
				axiWr(`OFS_CONTROL_WORD, ctl, OK);
			end
		join
		u_master.stop();
		cmpLink("addrAck", 8'h00, {7'h0, a1});
		cmpLink("txByte", v, got);
		cmpLink("events", 8'h02, evCnt[7:0]);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 0;
		axiRd(`OFS_CONTROL_WORD, {OK, 16'h0000, `CONTROL_RESET});
		axiRd(8'h1c, {ER, 32'h0000_0000});
		axiWr(8'h1c, 32'h0000_ffff, ER);
		axiWr(`OFS_STATUS_WORD, 32'h0000_ffff, OK);
		axiRd(`OFS_STATUS_WORD, {OK, 32'h0000_ffc0});
		axiWr(`OFS_STATUS_WORD, 32'h0000_0000, OK);
		$display("test registers done");
		// ordinary address with random upper bits that must be ignored
		adr = {3'($random(seed)), 7'(32'h0000_0004 + $unsigned($random(seed)) % 32'h0000_0074)};
		d = 8'($random(seed));
		axiWr(`OFS_OWN_ADDRESS, {22'h0, adr}, OK);
		axiWr(`OFS_CONTROL_WORD, 32'h0000_9000, OK);
		evCnt = 0;
		u_master.start();
		linkByte({adr[6:0], 1'b0}, 1'b0);
		linkByte(d, 1'b0);
		linkByte(~d, 1'b1);
		axiRd(`OFS_RECEIVE_BUFFER, {OK, 24'h0, d});
		// last event trails the ninth falling edge by a few clocks
		repeat (8) @(posedge clock);
		cmpLink("events", 8'h03, evCnt[7:0]);
		linkByte(d ^ 8'h5a, 1'b1);
		axiWr(`OFS_STATUS_WORD, 32'h0000_0000, OK);
		linkByte(~d, 1'b0);
		u_master.stop();
		axiRd(`OFS_RECEIVE_BUFFER, {OK, 24'h0, ~d});
		evCnt = 0;
		u_master.start();
		linkByte({adr[6:0] ^ 7'h01, 1'b0}, 1'b1);
		u_master.stop();
		cmpLink("events", 8'h00, evCnt[7:0]);
		u_master.start();
		rdPhase({adr[6:0], 1'b1}, ~d, 32'h0000_9000);
		$display("test short address done");
		adr = 10'($random(seed));
		axiWr(`OFS_OWN_ADDRESS, {22'h0, adr}, OK);
		axiRd(`OFS_OWN_ADDRESS, {OK, 22'h0, adr});
		axiWr(`OFS_CONTROL_WORD, 32'h0000_9400, OK);
		// write first with both bytes, then restart for the read
		u_master.start();
		linkByte({`TEN_BIT_PREFIX, adr[9:8], 1'b0}, 1'b0);
		linkByte(adr[7:0], 1'b0);
		u_master.start();
		rdPhase({`TEN_BIT_PREFIX, adr[9:8], 1'b1}, d, 32'h0000_9400);
		$display("test long address done");
		end_sim();
	end
endmodule // tb_i2c_slave
`default_nettype wire
